// ### hdl/repeater_reset_link_ctrl_regs.sv
// Reset and link control register bank of the repeater, reached over the serial target
// Behaviour
// RULE_01 - Registers are reachable over the serial target at any time after reset, no enable.
// RULE_02 - The controller must not write reserved codes such as speed 10/11 or role 11.
// RULE_03 - Reserved bits need not read back what was written; here they read as zero.
// RULE_04 - Offset 0x00 reads as all zero and ignores writes.
// RULE_05 - Writing one to bit 0 at offset 0x01 starts a soft reset and the bit clears itself.
// RULE_06 - A soft reset returns every read/write field to its power-on value.
// RULE_07 - Writing zero to the soft reset bit does nothing and the bit always reads zero.
// RULE_08 - Bits 7:6 at 0x02 pick speed: 00 negotiated, 01 low/full only, reset 00.
// RULE_09 - Bits 5:4 at 0x02 pick role; 00 is dual role, negotiated by the embedded host.
// RULE_10 - Role code 01 forces the host repeater role whatever configuration arrives.
// RULE_11 - Role code 10 forces the device repeater role whatever configuration arrives.
// RULE_12 - Configuration messages are still acknowledged while a role is forced.
// RULE_13 - The controller uses forced roles only with operational mode 2; the bench also writes role 01 with modes 0 and 3.
// RULE_14 - Mode 1 is deep standby with pins pulled low and registers kept; here only deep_standby_o is raised, no pin is driven.
// RULE_15 - Mode 2 enters connect-detect only at the write, ignored under an override; here it also needs exactly one role bit.
// RULE_16 - Mode 3 forces compliance L0, ignored unless exactly one role bit is set.
// RULE_17 - Bits 7:1 at 0x01 and bit 3 at 0x02 read as zero and ignore writes.
`timescale 1ns/100ps
`include "link_ctrl_regs.svh"

module repeater_reset_link_ctrl_regs import link_ctrl_pkg::*; #(
  parameter logic [6:0] I2C_BASE = `I2C_ADDR_BASE
) (
  input wire logic core_clk_i, // Core clock, 200 MHz
  input wire logic rst_b_i, // Reset pin, active low
  input wire logic scl_i, // Serial clock level
  input wire logic sda_i, // Serial data level
  input wire logic [1:0] addr_sel_i, // Target address select
  input wire logic cfg_msg_i, // Configuration message received
  input wire logic [1:0] cfg_role_i, // Role asked by that message
  input wire logic override_i, // Overriding condition present
  output logic sda_o, // Data line drive value
  output logic sda_oe_o, // Data line pulled low when high
  output logic [1:0] speed_ctrl_o, // Speed handling field
  output logic [1:0] role_ctrl_o, // Role field
  output logic [2:0] op_mode_o, // Operational mode field
  output logic deep_standby_o, // Deep standby active
  output logic conn_detect_o, // Enter connect-detect pulse
  output logic compliance_o, // Enter compliance L0 pulse
  output logic [1:0] cmd_role_o, // Role for the two pulses
  output logic [1:0] active_role_o, // Role in effect
  output logic cfg_ack_o, // Acknowledge pulse
  output logic soft_reset_o // Soft reset pulse
);

  logic [1:0] rst_sync;
  logic rst_int_b;
  ctrl_reg_t r;
  ctrl_reg_t next_r;
  logic [7:0] reg_addr;
  logic [7:0] rd_data;
  logic wr_stb;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic sda_oe;
  logic [2:0] wr_mode;
  logic [1:0] wr_role;

  // True when exactly one role bit is set
  function automatic logic role_single(input logic [1:0] role);
    role_single = role[0] ^ role[1];
  endfunction : role_single

  // Read view of the bank; reserved space and reserved bits read as zero
  function automatic logic [7:0] read_reg(input logic [7:0] addr, input ctrl_reg_t c);
    logic [7:0] val;
    val = `RD_ZERO;
    if (addr == `REG_LINK1_OFS) begin
      val[`SPEED_HI:`SPEED_LO] = c.speed;
      val[`ROLE_HI:`ROLE_LO] = c.role;
      val[`MODE_HI:`MODE_LO] = c.op_mode;
    end
    read_reg = val;
  endfunction : read_reg

  // Reset release through two flip-flops
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_int_b = rst_sync[1];

  // Serial target engine
  i2c_target_engine #(
    .BASE_ADDR(I2C_BASE)
  ) u_target (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_int_b),
    .addr_sel_i(addr_sel_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .rd_data_i(rd_data),
    .sda_oe_o(sda_oe),
    .reg_addr_o(reg_addr),
    .wr_stb_o(wr_stb),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data)
  );

  // Offset 0x00, bits 7:1 at 0x01 and bit 3 at 0x02 are never stored
  assign rd_data = read_reg(reg_addr, r); // RULE_03 RULE_04 RULE_17

  assign wr_mode = wr_data[`MODE_HI:`MODE_LO];
  assign wr_role = wr_data[`ROLE_HI:`ROLE_LO];

  // Register writes, mode commands and role tracking
  always_comb begin
    next_r = r;
    next_r.soft_rst = 1'b0;
    next_r.conn_det = 1'b0;
    next_r.compliance = 1'b0;
    next_r.cfg_ack = 1'b0;
    if (wr_stb && wr_addr == `REG_RESET_OFS) begin
      // A zero written here changes nothing
      if (wr_data[`SWRST_BIT]) begin // RULE_07
        next_r.soft_rst = 1'b1; // RULE_05
        next_r.speed = `SPEED_RST; // RULE_06
        next_r.role = `ROLE_RST; // RULE_06
        next_r.op_mode = `MODE_RST; // RULE_06
        next_r.active_role = ROLE_DUAL;
      end
    end else if (wr_stb && wr_addr == `REG_LINK1_OFS) begin
      next_r.speed = wr_data[`SPEED_HI:`SPEED_LO]; // RULE_08
      next_r.role = wr_role; // RULE_09
      next_r.op_mode = wr_mode;
      // Connect-detect acts only on the write itself
      if (wr_mode == MODE_CONN_DET && !override_i && role_single(wr_role)) begin
        next_r.conn_det = 1'b1; // RULE_15
        next_r.cmd_role = wr_role;
      end
      // Compliance needs exactly one role bit
      if (wr_mode == MODE_COMPLIANCE && role_single(wr_role)) begin
        next_r.compliance = 1'b1; // RULE_16
        next_r.cmd_role = wr_role;
      end
    end
    // Forced roles win over negotiated requests
    if (next_r.role == ROLE_HOST || next_r.role == ROLE_DEVICE) begin
      next_r.active_role = next_r.role; // RULE_10 RULE_11
    end else if (cfg_msg_i && role_single(cfg_role_i)) begin
      next_r.active_role = cfg_role_i; // RULE_09
    end
    // Every configuration message is acknowledged
    next_r.cfg_ack = cfg_msg_i; // RULE_12
    next_r.standby = (next_r.op_mode == MODE_STANDBY); // RULE_14
  end

  // Bank state register
  always_ff @(posedge core_clk_i or negedge rst_int_b) begin
    if (!rst_int_b) begin
      r <= '{speed: `SPEED_RST, role: `ROLE_RST, op_mode: `MODE_RST, soft_rst: 1'b0,
             standby: 1'b0, conn_det: 1'b0, compliance: 1'b0, cmd_role: 2'h0,
             active_role: 2'h0, cfg_ack: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from the state register; sda_o tied low, sda_oe_o from the target engine
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_oe;
  assign speed_ctrl_o = r.speed;
  assign role_ctrl_o = r.role;
  assign op_mode_o = r.op_mode;
  assign deep_standby_o = r.standby;
  assign conn_detect_o = r.conn_det;
  assign compliance_o = r.compliance;
  assign cmd_role_o = r.cmd_role;
  assign active_role_o = r.active_role;
  assign cfg_ack_o = r.cfg_ack;
  assign soft_reset_o = r.soft_rst;

  // Offset 0x00 always reads zero
  a_unused_field_reg_zero: assert property ( // RULE_04
    @(posedge core_clk_i) disable iff (!rst_int_b)
    reg_addr == `REG_UNUSED_FIELD_OFS |-> rd_data == `RD_ZERO)
    else $error("reserved offset read not zero");

  // Reset control register reads zero, bit 0 included
  a_swrst_read_zero: assert property ( // RULE_07
    @(posedge core_clk_i) disable iff (!rst_int_b)
    reg_addr == `REG_RESET_OFS |-> rd_data == `RD_ZERO)
    else $error("reset control read not zero");

  // Reserved bit 3 of link control reads zero
  a_link_unused_field_bit: assert property ( // RULE_17
    @(posedge core_clk_i) disable iff (!rst_int_b)
    reg_addr == `REG_LINK1_OFS |-> rd_data[`LINK1_UNUSED_FIELD_BIT] == 1'b0)
    else $error("link control bit 3 not zero");

  // Soft reset write pulses once and restores defaults
  a_swrst_defaults: assert property ( // RULE_05
    @(posedge core_clk_i) disable iff (!rst_int_b)
    wr_stb && wr_addr == `REG_RESET_OFS && wr_data[`SWRST_BIT]
    |=> soft_reset_o && speed_ctrl_o == `SPEED_RST && role_ctrl_o == `ROLE_RST
        && op_mode_o == `MODE_RST ##1 !soft_reset_o)
    else $error("soft reset did not restore defaults");

  // Writing zero leaves the bank alone
  a_swrst_zero_nop: assert property ( // RULE_07
    @(posedge core_clk_i) disable iff (!rst_int_b)
    wr_stb && wr_addr == `REG_RESET_OFS && !wr_data[`SWRST_BIT]
    |=> !soft_reset_o && $stable(speed_ctrl_o) && $stable(role_ctrl_o)
        && $stable(op_mode_o))
    else $error("zero write to reset bit had an effect");

  // Soft reset pulses only after a write to offset 0x01
  a_swrst_cause: assert property ( // RULE_06
    @(posedge core_clk_i) disable iff (!rst_int_b)
    soft_reset_o |-> $past(wr_stb) && $past(wr_addr) == `REG_RESET_OFS)
    else $error("soft reset without cause");

  // Speed field follows the written bits
  a_speed_write: assert property ( // RULE_08
    @(posedge core_clk_i) disable iff (!rst_int_b)
    wr_stb && wr_addr == `REG_LINK1_OFS
    |=> speed_ctrl_o == $past(wr_data[`SPEED_HI:`SPEED_LO]))
    else $error("speed field not updated");

  // Forced host role holds regardless of messages
  a_forced_host: assert property ( // RULE_10
    @(posedge core_clk_i) disable iff (!rst_int_b)
    role_ctrl_o == ROLE_HOST |-> active_role_o == ROLE_HOST)
    else $error("forced host role not in effect");

  // Forced device role holds regardless of messages
  a_forced_device: assert property ( // RULE_11
    @(posedge core_clk_i) disable iff (!rst_int_b)
    role_ctrl_o == ROLE_DEVICE |-> active_role_o == ROLE_DEVICE)
    else $error("forced device role not in effect");

  // Messages acknowledged one cycle later, even when forced
  a_cfg_ack: assert property ( // RULE_12
    @(posedge core_clk_i) disable iff (!rst_int_b)
    cfg_msg_i |=> cfg_ack_o)
    else $error("configuration message not acknowledged");

  // Standby flag matches mode 1
  a_deep_standby: assert property ( // RULE_14
    @(posedge core_clk_i) disable iff (!rst_int_b)
    deep_standby_o == (op_mode_o == MODE_STANDBY))
    else $error("standby flag disagrees with mode");

  // Connect-detect refused under an override
  a_conn_override: assert property ( // RULE_15
    @(posedge core_clk_i) disable iff (!rst_int_b)
    wr_stb && wr_addr == `REG_LINK1_OFS && override_i |=> !conn_detect_o)
    else $error("connect-detect taken under override");

  // Connect-detect taken on a clean write
  a_conn_taken: assert property ( // RULE_15
    @(posedge core_clk_i) disable iff (!rst_int_b)
    wr_stb && wr_addr == `REG_LINK1_OFS && wr_mode == MODE_CONN_DET && !override_i
    && role_single(wr_role) |=> conn_detect_o && cmd_role_o == $past(wr_role))
    else $error("connect-detect not issued");

  // Compliance refused without a single role bit
  a_compliance_role: assert property ( // RULE_16
    @(posedge core_clk_i) disable iff (!rst_int_b)
    compliance_o |-> role_single(cmd_role_o) && op_mode_o == MODE_COMPLIANCE)
    else $error("compliance with bad role");

  // Acknowledge only answers a message
  a_ack_cause: assert property ( // RULE_12
    @(posedge core_clk_i) disable iff (!rst_int_b)
    cfg_ack_o |-> $past(cfg_msg_i))
    else $error("acknowledge without message");

  // Dual role takes the role a message asks for
  a_dual_follow: assert property ( // RULE_09
    @(posedge core_clk_i) disable iff (!rst_int_b)
    cfg_msg_i && role_ctrl_o == ROLE_DUAL && role_single(cfg_role_i) && !wr_stb
    |=> active_role_o == $past(cfg_role_i))
    else $error("dual role did not follow message");

  // Connect-detect is a single-cycle pulse
  a_conn_pulse: assert property ( // RULE_15
    @(posedge core_clk_i) disable iff (!rst_int_b)
    conn_detect_o |=> !conn_detect_o)
    else $error("connect-detect longer than one cycle");

  // Compliance is a single-cycle pulse
  a_compl_pulse: assert property ( // RULE_16
    @(posedge core_clk_i) disable iff (!rst_int_b)
    compliance_o |=> !compliance_o)
    else $error("compliance longer than one cycle");

  // Fields are kept while in standby with no write
  a_standby_kept: assert property ( // RULE_14
    @(posedge core_clk_i) disable iff (!rst_int_b)
    deep_standby_o && !wr_stb |=> $stable(speed_ctrl_o) && $stable(role_ctrl_o)
    && $stable(op_mode_o))
    else $error("fields changed in standby");

endmodule : repeater_reset_link_ctrl_regs

// ### hdl/link_ctrl_regs.svh
// Register offsets, field positions and reset values of the repeater control bank
`ifndef LINK_CTRL_REGS_SVH
`define LINK_CTRL_REGS_SVH

// Register offsets
`define REG_UNUSED_FIELD_OFS 8'h00
`define REG_RESET_OFS 8'h01
`define REG_LINK1_OFS 8'h02

// Reset control fields
`define SWRST_BIT 0

// Link control 1 fields
`define SPEED_HI 7
`define SPEED_LO 6
`define ROLE_HI 5
`define ROLE_LO 4
`define LINK1_UNUSED_FIELD_BIT 3
`define MODE_HI 2
`define MODE_LO 0

// Power-on values of the link control fields
`define SPEED_RST 2'h0
`define ROLE_RST 2'h0
`define MODE_RST 3'h0
`define RD_ZERO 8'h00

// Target address and byte framing
`define I2C_ADDR_BASE 7'h40
`define I2C_BYTE_BITS 4'h8
`define I2C_LAST_BIT 4'h7

`endif

// ### hdl/link_ctrl_pkg.sv
// Types shared by the control bank and its serial target engine
package link_ctrl_pkg;

  typedef enum logic [4:0] {
    I2C_IDLE = 5'h01,
    I2C_RX = 5'h02,
    I2C_ACK_OUT = 5'h04,
    I2C_TX = 5'h08,
    I2C_ACK_IN = 5'h10
  } i2c_state_t;

  typedef enum logic [1:0] {
    PH_ADDR = 2'h0,
    PH_PTR = 2'h1,
    PH_DATA = 2'h2
  } i2c_phase_t;

  typedef enum logic [2:0] {
    MODE_AUTO = 3'h0,
    MODE_STANDBY = 3'h1,
    MODE_CONN_DET = 3'h2,
    MODE_COMPLIANCE = 3'h3
  } op_mode_t;

  typedef enum logic [1:0] {
    ROLE_DUAL = 2'h0,
    ROLE_HOST = 2'h1,
    ROLE_DEVICE = 2'h2,
    ROLE_UNUSED_FIELD = 2'h3
  } role_t;

  typedef enum logic [1:0] {
    SPEED_AUTO = 2'h0,
    SPEED_LSFS = 2'h1
  } speed_t;

  typedef struct packed {
    i2c_state_t state;
    i2c_phase_t phase;
    logic scl_q;
    logic sda_q;
    logic [7:0] shreg;
    logic [3:0] bitcnt;
    logic rnw;
    logic nack;
    logic [7:0] ptr;
    logic sda_oe;
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
  } i2c_reg_t;

  typedef struct packed {
    logic [1:0] speed;
    logic [1:0] role;
    logic [2:0] op_mode;
    logic soft_rst;
    logic standby;
    logic conn_det;
    logic compliance;
    logic [1:0] cmd_role;
    logic [1:0] active_role;
    logic cfg_ack;
  } ctrl_reg_t;

endpackage : link_ctrl_pkg

// ### hdl/i2c_target_engine.sv
// Serial register target: address match, pointer byte, write and read bytes
`timescale 1ns/100ps
`include "link_ctrl_regs.svh"

module i2c_target_engine import link_ctrl_pkg::*; #(
  parameter logic [6:0] BASE_ADDR = `I2C_ADDR_BASE
) (
  input wire logic core_clk_i, // Core clock
  input wire logic rst_b_i, // Synchronised reset, active low
  input wire logic [1:0] addr_sel_i, // Target address select
  input wire logic scl_i, // Serial clock level
  input wire logic sda_i, // Serial data level
  input wire logic [7:0] rd_data_i, // Read value at reg_addr_o
  output logic sda_oe_o, // Pull data line low
  output logic [7:0] reg_addr_o, // Register pointer
  output logic wr_stb_o, // One-cycle write strobe
  output logic [7:0] wr_addr_o, // Write offset
  output logic [7:0] wr_data_o // Write value
);

  i2c_reg_t r;
  i2c_reg_t next_r;
  logic start;
  logic stop;
  logic rise;
  logic fall;
  logic [6:0] dev_addr;

  function automatic logic [7:0] bump(input logic [7:0] p);
    bump = p + 8'h01;
  endfunction : bump

  // Bus conditions seen on the sampled lines
  assign start = r.scl_q & scl_i & r.sda_q & ~sda_i;
  assign stop = r.scl_q & scl_i & ~r.sda_q & sda_i;
  assign rise = scl_i & ~r.scl_q;
  assign fall = ~scl_i & r.scl_q;
  assign dev_addr = BASE_ADDR | {5'h00, addr_sel_i};

  // Byte engine; no enable step, so access is taken whenever reset is released
  always_comb begin
    next_r = r; // RULE_01
    next_r.scl_q = scl_i;
    next_r.sda_q = sda_i;
    next_r.wr_stb = 1'b0;
    if (start) begin
      next_r.state = I2C_RX;
      next_r.phase = PH_ADDR;
      next_r.bitcnt = 4'h0;
      next_r.sda_oe = 1'b0;
    end else if (stop) begin
      next_r.state = I2C_IDLE;
      next_r.sda_oe = 1'b0;
    end else begin
      case (r.state)
        I2C_RX: begin
          if (rise && r.bitcnt != `I2C_BYTE_BITS) begin
            next_r.shreg = {r.shreg[6:0], sda_i};
            next_r.bitcnt = r.bitcnt + 4'h1;
          end else if (fall && r.bitcnt == `I2C_BYTE_BITS) begin
            next_r.bitcnt = 4'h0;
            next_r.sda_oe = 1'b1;
            next_r.state = I2C_ACK_OUT;
            case (r.phase)
              PH_ADDR: begin
                next_r.rnw = r.shreg[0];
                if (r.shreg[7:1] != dev_addr) begin
                  next_r.sda_oe = 1'b0;
                  next_r.state = I2C_IDLE;
                end
              end
              PH_PTR: begin
                next_r.ptr = r.shreg;
              end
              default: begin
                next_r.wr_stb = 1'b1;
                next_r.wr_addr = r.ptr;
                next_r.wr_data = r.shreg;
                next_r.ptr = bump(r.ptr);
              end
            endcase
          end
        end
        I2C_ACK_OUT: begin
          if (fall && r.rnw) begin
            next_r.state = I2C_TX;
            next_r.shreg = rd_data_i;
            next_r.sda_oe = ~rd_data_i[7];
            next_r.ptr = bump(r.ptr);
          end else if (fall) begin
            next_r.sda_oe = 1'b0;
            next_r.state = I2C_RX;
            next_r.phase = (r.phase == PH_ADDR) ? PH_PTR : PH_DATA;
          end
        end
        I2C_TX: begin
          if (fall && r.bitcnt == `I2C_LAST_BIT) begin
            next_r.sda_oe = 1'b0;
            next_r.state = I2C_ACK_IN;
          end else if (fall) begin
            next_r.shreg = {r.shreg[6:0], 1'b0};
            next_r.sda_oe = ~r.shreg[6];
            next_r.bitcnt = r.bitcnt + 4'h1;
          end
        end
        I2C_ACK_IN: begin
          if (rise) begin
            next_r.nack = sda_i;
          end else if (fall && r.nack) begin
            next_r.state = I2C_IDLE;
          end else if (fall) begin
            next_r.state = I2C_TX;
            next_r.bitcnt = 4'h0;
            next_r.shreg = rd_data_i;
            next_r.sda_oe = ~rd_data_i[7];
            next_r.ptr = bump(r.ptr);
          end
        end
        default: begin
          next_r.state = I2C_IDLE;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r <= '{state: I2C_IDLE, phase: PH_ADDR, scl_q: 1'b1, sda_q: 1'b1,
             shreg: 8'h00, bitcnt: 4'h0, rnw: 1'b0, nack: 1'b0, ptr: 8'h00,
             sda_oe: 1'b0, wr_stb: 1'b0, wr_addr: 8'h00, wr_data: 8'h00};
    end else begin
      r <= next_r;
    end
  end

  assign sda_oe_o = r.sda_oe;
  assign reg_addr_o = r.ptr;
  assign wr_stb_o = r.wr_stb;
  assign wr_addr_o = r.wr_addr;
  assign wr_data_o = r.wr_data;

endmodule : i2c_target_engine

// ### testbench/i2c_ctrl_model.sv
// Serial bus controller model that drives clock and pulls data low
`timescale 1ns/100ps

module i2c_ctrl_model #(
  parameter int HALF = 4 // Core cycles per half bit
) (
  input wire logic core_clk_i, // Core clock
  input wire logic sda_i, // Resolved data line
  output logic scl_o, // Serial clock, idles high
  output logic sda_oe_o // Pulls data line low when high
);
  // Both lines released at start
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  // Half bit wait; lines change just after the edge
  task automatic hb();
    repeat (HALF) @(posedge core_clk_i);
    #1;
  endtask : hb

  // Start, also used as repeated start
  task automatic start_cond();
    sda_oe_o = 1'b0;
    hb();
    scl_o = 1'b1;
    hb();
    sda_oe_o = 1'b1;
    hb();
    scl_o = 1'b0;
    hb();
  endtask : start_cond

  // Stop ends the frame with both lines high
  task automatic stop_cond();
    sda_oe_o = 1'b1;
    hb();
    scl_o = 1'b1;
    hb();
    sda_oe_o = 1'b0;
    hb();
  endtask : stop_cond

  // Sends a byte msb first and samples the acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_oe_o = ~b[i];
      hb();
      scl_o = 1'b1;
      hb();
      scl_o = 1'b0;
      hb();
    end
    sda_oe_o = 1'b0;
    hb();
    scl_o = 1'b1;
    hb();
    ack = (sda_i === 1'b0);
    scl_o = 1'b0;
    hb();
  endtask : send_byte

  // Receives a byte; ack_out high drives an acknowledge
  task automatic recv_byte(input logic ack_out, output logic [7:0] b);
    sda_oe_o = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      hb();
      scl_o = 1'b1;
      hb();
      b[i] = sda_i;
      scl_o = 1'b0;
    end
    hb();
    sda_oe_o = ack_out;
    hb();
    scl_o = 1'b1;
    hb();
    scl_o = 1'b0;
    hb();
  endtask : recv_byte

  // Pointer then one data byte
  task automatic wr_reg(input logic [6:0] dev, input logic [7:0] ptr,
                        input logic [7:0] dat, output logic ok);
    logic a0;
    logic a1;
    logic a2;
    start_cond();
    send_byte({dev, 1'b0}, a0);
    send_byte(ptr, a1);
    send_byte(dat, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask : wr_reg

  // Pointer, repeated start, one byte closed by a refusal
  task automatic rd_reg(input logic [6:0] dev, input logic [7:0] ptr,
                        output logic [7:0] dat, output logic ok);
    logic a0;
    logic a1;
    logic a2;
    start_cond();
    send_byte({dev, 1'b0}, a0);
    send_byte(ptr, a1);
    start_cond();
    send_byte({dev, 1'b1}, a2);
    recv_byte(1'b0, dat);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask : rd_reg
endmodule : i2c_ctrl_model

// ### testbench/repeater_reset_link_ctrl_regs_tb.sv
// Self-checking bench for the reset and link control register bank
`timescale 1ns/100ps
`include "link_ctrl_regs.svh"

module repeater_reset_link_ctrl_regs_tb import link_ctrl_pkg::*; ;
  localparam logic [6:0] DEV = `I2C_ADDR_BASE | 7'h01; // Select input set to 01
  logic core_clk;
  logic rst_b = 1'b0;
  logic [1:0] addr_sel = 2'h1;
  logic cfg_msg = 1'b0;
  logic [1:0] cfg_role = 2'h0;
  logic override = 1'b0;
  logic scl;
  logic ctrl_oe;
  logic dut_oe;
  logic dut_sda;
  wire sda_line;
  logic [1:0] speed, role, active, cmd;
  logic [2:0] mode;
  logic standby, conn_det, compl, cfg_ack, soft_rst, ok;
  logic [7:0] got;
  int n_mismatch = 0;
  int check_count = 0;
  int n_cd = 0;
  int n_cp = 0;
  int n_sr = 0;
  int n_ack = 0;
  int b_cd, b_cp, b_sr, b_ack;

  // Open-drain data line with pull-up
  assign sda_line = (dut_oe ? dut_sda : 1'b1) & ~ctrl_oe;

  // 200 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  i2c_ctrl_model i_i2c_ctrl_model (.core_clk_i(core_clk), .sda_i(sda_line), .scl_o(scl),
    .sda_oe_o(ctrl_oe));

  repeater_reset_link_ctrl_regs i_repeater_reset_link_ctrl_regs (.core_clk_i(core_clk),
    .rst_b_i(rst_b), .scl_i(scl), .sda_i(sda_line), .addr_sel_i(addr_sel),
    .cfg_msg_i(cfg_msg), .cfg_role_i(cfg_role), .override_i(override), .sda_o(dut_sda),
    .sda_oe_o(dut_oe), .speed_ctrl_o(speed), .role_ctrl_o(role), .op_mode_o(mode),
    .deep_standby_o(standby), .conn_detect_o(conn_det), .compliance_o(compl),
    .cmd_role_o(cmd), .active_role_o(active), .cfg_ack_o(cfg_ack), .soft_reset_o(soft_rst));

  // Counts the cycles each pulse output stands high
  always @(posedge core_clk) begin
    if (conn_det === 1'b1) n_cd++;
    if (compl === 1'b1) n_cp++;
    if (soft_rst === 1'b1) n_sr++;
    if (cfg_ack === 1'b1) n_ack++;
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t %s: got %h expected %h", $time, m, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] ptr, input logic [7:0] dat);
    i_i2c_ctrl_model.wr_reg(DEV, ptr, dat, ok);
    chk({7'h00, ok}, 8'h01, "write acknowledge");
  endtask : wr

  task automatic rd(input logic [7:0] ptr, input logic [7:0] e, input string m);
    i_i2c_ctrl_model.rd_reg(DEV, ptr, got, ok);
    chk({7'h00, ok}, 8'h01, "read acknowledge");
    chk(got, e, m);
  endtask : rd

  // One configuration message from the embedded host
  task automatic cfg(input logic [1:0] r);
    @(posedge core_clk);
    #1;
    cfg_msg = 1'b1;
    cfg_role = r;
    @(posedge core_clk);
    #1;
    cfg_msg = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
  endtask : cfg

  task automatic snap();
    b_cd = n_cd;
    b_cp = n_cp;
    b_sr = n_sr;
    b_ack = n_ack;
  endtask : snap

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  // Watchdog cuts a hang short
  initial begin
    repeat (80000) @(posedge core_clk);
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    logic [1:0] r;
    repeat (10) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    repeat (5) @(posedge core_clk);
    #1;
    rd(`REG_UNUSED_FIELD_OFS, 8'h00, "offset 0 after reset");
    rd(`REG_RESET_OFS, 8'h00, "reset reg after reset");
    rd(`REG_LINK1_OFS, 8'h00, "link reg after reset");
    $display("test reset values done");
    snap();
    wr(`REG_UNUSED_FIELD_OFS, 8'hFF);
    rd(`REG_UNUSED_FIELD_OFS, 8'h00, "offset 0 ignores writes");
    wr(`REG_RESET_OFS, 8'hFE);
    rd(`REG_RESET_OFS, 8'h00, "reset reg reserved bits");
    chk(8'(n_sr - b_sr), 8'h00, "zero write starts no reset");
    wr(`REG_LINK1_OFS, 8'h48);
    rd(`REG_LINK1_OFS, 8'h40, "link reg bit 3 reads zero");
    chk({6'h00, speed}, 8'h01, "speed low/full only");
    wr(`REG_LINK1_OFS, 8'h00);
    chk({6'h00, speed}, 8'h00, "speed negotiated");
    $display("test reserved and speed done");
    // Forced roles, always written with mode 2 and never a reserved code
    for (int i = 1; i < 3; i++) begin
      r = 2'(i);
      snap();
      wr(`REG_LINK1_OFS, {2'h0, r, 4'h2});
      chk({6'h00, role}, {6'h00, r}, "role field");
      chk({6'h00, active}, {6'h00, r}, "forced role in effect");
      chk({6'h00, cmd}, {6'h00, r}, "connect-detect role");
      chk(8'(n_cd - b_cd), 8'h01, "connect-detect pulse");
      cfg(~r);
      chk({6'h00, active}, {6'h00, r}, "forced role kept");
      chk(8'(n_ack - b_ack), 8'h01, "message acknowledged");
    end
    $display("test forced roles done");
    snap();
    wr(`REG_LINK1_OFS, 8'h00);
    cfg(ROLE_HOST);
    chk({6'h00, active}, {6'h00, ROLE_HOST}, "dual role follows message");
    chk(8'(n_ack - b_ack), 8'h01, "dual message acknowledged");
    cfg(2'h3);
    chk({6'h00, active}, {6'h00, ROLE_HOST}, "odd message ignored");
    chk(8'(n_ack - b_ack), 8'h02, "odd message acknowledged");
    override = 1'b1;
    wr(`REG_LINK1_OFS, 8'h12);
    override = 1'b0;
    wr(`REG_LINK1_OFS, 8'h10);
    chk(8'(n_cd - b_cd), 8'h00, "override blocks connect-detect");
    wr(`REG_LINK1_OFS, 8'h03);
    chk(8'(n_cp - b_cp), 8'h00, "compliance with no role bit");
    wr(`REG_LINK1_OFS, 8'h13);
    chk(8'(n_cp - b_cp), 8'h01, "compliance pulse");
    $display("test modes done");
    wr(`REG_LINK1_OFS, 8'h41);
    chk({7'h00, standby}, 8'h01, "deep standby");
    rd(`REG_LINK1_OFS, 8'h41, "contents kept in standby");
    snap();
    wr(`REG_RESET_OFS, 8'h01);
    chk(8'(n_sr - b_sr), 8'h01, "soft reset pulse");
    chk({1'b0, speed, role, mode}, 8'h00, "fields to defaults");
    chk({7'h00, standby}, 8'h00, "standby left");
    rd(`REG_LINK1_OFS, 8'h00, "link reg after soft reset");
    rd(`REG_RESET_OFS, 8'h00, "reset bit clears itself");
    $display("test soft reset done");
    i_i2c_ctrl_model.wr_reg(7'h42, `REG_LINK1_OFS, 8'h40, ok);
    chk({7'h00, ok}, 8'h00, "other address refused");
    chk({6'h00, speed}, 8'h00, "refused write ignored");
    wr(`REG_LINK1_OFS, 8'h40);
    @(posedge core_clk);
    #1;
    rst_b = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chk({6'h00, speed}, 8'h00, "pin reset clears speed");
    rst_b = 1'b1;
    repeat (5) @(posedge core_clk);
    #1;
    rd(`REG_LINK1_OFS, 8'h00, "link reg after pin reset");
    $display("test address and pin reset done");
    print_verdict();
  end
endmodule : repeater_reset_link_ctrl_regs_tb
